/* rtl/hps_regs.svh */
// Timing figures and reset values of the handset power sequencer.
// Assumes a single 200 MHz timebase; all times are in microseconds.
`ifndef HPS_REGS_SVH
`define HPS_REGS_SVH

`define HPS_CLK_MHZ        200
`define HPS_DEBOUNCE_US    32000
`define HPS_RESET_DLY_US   20000
`define HPS_REG_STD_US     125
`define HPS_REG_OPT_US     10000
`define HPS_HOLD_US        500000
`define HPS_US_TO_CYC(us)  ((us) * `HPS_CLK_MHZ)

// Inputs idle with key released and charger absent
`define HPS_IN_RESET       7'h20
// Regulators off, host reset low, interrupt inactive
`define HPS_OUT_RESET      4'h1
`define HPS_IN_WIDTH       7
`define HPS_KEY_BIT        6
`define HPS_CHG_BIT        5
`define HPS_TIMER_WIDTH    32

`endif

/* rtl/hps_pkg.sv */
// Types shared by the handset power sequencer.
// Field order of the pin structs matches the reset values in the header.
package hps_pkg;

   typedef struct packed {
      logic power_key_input;
      logic charger_detect_n;
      logic host_power_hold;
      logic first_above_upper;
      logic first_above_lower;
      logic second_above_upper;
      logic second_above_lower;
   } hps_inputs_type;

   typedef struct packed {
      logic first_regulator_enable;
      logic second_regulator_enable;
      logic host_reset_n;
      logic power_key_irq_n;
   } hps_outputs_type;

   typedef enum logic [3:0] {
      ST_OFF,
      ST_WAIT_FIRST,
      ST_REG_DLY,
      ST_WAIT_SECOND,
      ST_RST_DLY,
      ST_HOLD_WAIT,
      ST_ON,
      ST_DOWN_RST,
      ST_DOWN_SECOND,
      ST_DOWN_REG
   } hps_state_type;

endpackage

/* rtl/hps_sequencer.sv */
// Power-up and power-down sequencer of a handset power manager.
// Assumes all pins and comparator outputs are asynchronous to clk.
`timescale 1ns/1ps
`include "hps_regs.svh"

// Contract
// - Each of the two regulators has an internal good flag that sets above the upper threshold and clears below the lower one.
// - A good flag follows its threshold crossing within 10 us, typically 6 us.
// - Power key and charger detect count only after staying stable for the debounce time of 32 ms.
// - Host reset is released one reset delay of 20 ms after the second good flag rises.
// - On power-down the second regulator is disabled one reset delay after host reset goes low.
// - The second regulator is enabled one regulator delay of 125 us after the first good flag rises.
// - On power-down the first regulator is disabled one regulator delay after the second good flag falls.
// - A factory strap selects an optional regulator delay of 10 ms instead of the standard one.
// - A power-hold timer of 500 ms starts when host reset goes high, and the host must raise power-hold before it ends.
// - A debounced key press asserts the key interrupt and enables the first regulator.
// - Power-hold in time clears the interrupt; a timeout clears it, asserts host reset and powers down.
// - Either good flag falling drives host reset low at once and leads to shutdown.
// - While the charger is present there is no power-down, and a charger start raises no interrupt; the code still powers down when a good flag falls.
module hps_sequencer #(
   parameter int unsigned DEBOUNCE_CYCLES = `HPS_US_TO_CYC(`HPS_DEBOUNCE_US),
   parameter int unsigned RESET_CYCLES    = `HPS_US_TO_CYC(`HPS_RESET_DLY_US),
   parameter int unsigned REG_STD_CYCLES  = `HPS_US_TO_CYC(`HPS_REG_STD_US),
   parameter int unsigned REG_OPT_CYCLES  = `HPS_US_TO_CYC(`HPS_REG_OPT_US),
   parameter int unsigned HOLD_CYCLES     = `HPS_US_TO_CYC(`HPS_HOLD_US)
) (
   // Clock and reset
   input  wire logic                     clk,
   input  wire logic                     reset,
   // Factory strap: high selects the optional regulator delay
   input  wire logic                     delay_option,
   // Pins and comparator outputs
   input  wire hps_pkg::hps_inputs_type  pins,
   // Regulator enables, host reset and key interrupt
   output hps_pkg::hps_outputs_type      outs
);

   if (DEBOUNCE_CYCLES < 2 || RESET_CYCLES < 2 || REG_STD_CYCLES < 2 ||
       REG_OPT_CYCLES < 2 || HOLD_CYCLES < 2) begin : g_bad_param
      $error("hps_sequencer: every delay needs at least two cycles");
   end

   logic [`HPS_IN_WIDTH-1:0]    sync1;
   logic [`HPS_IN_WIDTH-1:0]    sync2;
   logic [`HPS_IN_WIDTH-1:0]    sync3;
   logic [`HPS_IN_WIDTH-1:0]    filt;
   logic [1:0]                  deb;
   logic [`HPS_TIMER_WIDTH-1:0] deb_cnt [2];
   logic [1:0]                  good;
   logic                        opt_sel;
   logic                        irq_n;
   logic [`HPS_TIMER_WIDTH-1:0] timer;
   hps_pkg::hps_state_type      state;
   hps_pkg::hps_state_type      next_state;
   hps_pkg::hps_inputs_type     f;
   logic                        key_db;
   logic                        charger_n_db;
   logic                        timer_done;

   assign f            = filt;
   assign key_db       = deb[1];
   assign charger_n_db = deb[0];

   // Three-stage synchroniser; a change is taken once stages two and three agree
   always_ff @(posedge clk) begin
      if (reset) begin
         sync1 <= `HPS_IN_RESET;
         sync2 <= `HPS_IN_RESET;
         sync3 <= `HPS_IN_RESET;
      end else begin
         sync1 <= pins;
         sync2 <= sync1;
         sync3 <= sync2;
      end
   end

   // Filtered level per input
   for (genvar i = 0; i < `HPS_IN_WIDTH; i++) begin : g_filt
      always_ff @(posedge clk) begin
         if (reset) begin
            filt[i] <= 1'((`HPS_IN_RESET) >> i);
         end else if (sync2[i] == sync3[i]) begin
            filt[i] <= sync3[i];
         end
      end
   end

   // Debounce key (index 1) and charger (index 0); only a full stable span flips the level
   for (genvar j = 0; j < 2; j++) begin : g_deb
      localparam int BIT = (j == 1) ? `HPS_KEY_BIT : `HPS_CHG_BIT;
      always_ff @(posedge clk) begin
         if (reset) begin
            deb[j]     <= 1'((`HPS_IN_RESET) >> BIT);
            deb_cnt[j] <= '0;
         end else if (filt[BIT] == deb[j]) begin
            deb_cnt[j] <= '0; // Glitch restarts the span
         end else if (deb_cnt[j] == DEBOUNCE_CYCLES - 1) begin
            deb[j]     <= filt[BIT];
            deb_cnt[j] <= '0;
         end else begin
            deb_cnt[j] <= deb_cnt[j] + 1'b1;
         end
      end
   end

   // Good flags with hysteresis; sync path is a few cycles, well inside 10 us
   always_ff @(posedge clk) begin
      if (reset) begin
         good <= 2'h0;
      end else begin
         if (f.first_above_upper) begin
            good[0] <= 1'b1;
         end else if (!f.first_above_lower) begin
            good[0] <= 1'b0;
         end
         if (f.second_above_upper) begin
            good[1] <= 1'b1;
         end else if (!f.second_above_lower) begin
            good[1] <= 1'b0;
         end
      end
   end

   // Strap caught while reset is held; it must not change in service
   always_ff @(posedge clk) begin
      if (reset) begin
         opt_sel <= delay_option;
      end
   end

   // Delay that applies to a given state
   function automatic logic [`HPS_TIMER_WIDTH-1:0] delay_of(input hps_pkg::hps_state_type s,
                                                           input logic opt);
      case (s)
         hps_pkg::ST_REG_DLY,
         hps_pkg::ST_DOWN_REG:  delay_of = opt ? REG_OPT_CYCLES : REG_STD_CYCLES;
         hps_pkg::ST_RST_DLY,
         hps_pkg::ST_DOWN_RST:  delay_of = RESET_CYCLES;
         hps_pkg::ST_HOLD_WAIT: delay_of = HOLD_CYCLES;
         default:               delay_of = '1;
      endcase
   endfunction

   assign timer_done = (timer == delay_of(state, opt_sel) - 1'b1);

   // Shared timer restarts on every state change
   always_ff @(posedge clk) begin
      if (reset || state != next_state) begin
         timer <= '0;
      end else if (timer != '1) begin
         timer <= timer + 1'b1;
      end
   end

   // Sequence control
   always_comb begin
      next_state = state;
      case (state)
         hps_pkg::ST_OFF: begin
            if (key_db || !charger_n_db) begin
               next_state = hps_pkg::ST_WAIT_FIRST;
            end
         end
         hps_pkg::ST_WAIT_FIRST: begin
            if (good[0]) begin
               next_state = hps_pkg::ST_REG_DLY;
            end
         end
         hps_pkg::ST_REG_DLY: begin
            if (!good[0]) begin
               next_state = hps_pkg::ST_DOWN_RST;
            end else if (timer_done) begin
               next_state = hps_pkg::ST_WAIT_SECOND;
            end
         end
         hps_pkg::ST_WAIT_SECOND: begin
            if (!good[0]) begin
               next_state = hps_pkg::ST_DOWN_RST;
            end else if (good[1]) begin
               next_state = hps_pkg::ST_RST_DLY;
            end
         end
         hps_pkg::ST_RST_DLY: begin
            if (good != 2'h3) begin
               next_state = hps_pkg::ST_DOWN_RST;
            end else if (timer_done) begin
               next_state = hps_pkg::ST_HOLD_WAIT;
            end
         end
         hps_pkg::ST_HOLD_WAIT: begin
            if (good != 2'h3) begin
               next_state = hps_pkg::ST_DOWN_RST;
            end else if (f.host_power_hold) begin
               next_state = hps_pkg::ST_ON;
            end else if (timer_done) begin
               // Charger keeps the set running despite a missing hold
               next_state = charger_n_db ? hps_pkg::ST_DOWN_RST : hps_pkg::ST_ON;
            end
         end
         hps_pkg::ST_ON: begin
            if (good != 2'h3) begin
               next_state = hps_pkg::ST_DOWN_RST;
            end else if (!f.host_power_hold && charger_n_db) begin
               next_state = hps_pkg::ST_DOWN_RST;
            end
         end
         hps_pkg::ST_DOWN_RST: begin
            if (timer_done) begin
               next_state = hps_pkg::ST_DOWN_SECOND;
            end
         end
         hps_pkg::ST_DOWN_SECOND: begin
            if (!good[1]) begin
               next_state = hps_pkg::ST_DOWN_REG;
            end
         end
         hps_pkg::ST_DOWN_REG: begin
            if (timer_done) begin
               next_state = hps_pkg::ST_OFF;
            end
         end
         default: next_state = hps_pkg::ST_OFF;
      endcase
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         state <= hps_pkg::ST_OFF;
      end else begin
         state <= next_state;
      end
   end

   // Interrupt only on a key start; a charger start leaves it high
   always_comb begin
      irq_n = outs.power_key_irq_n;
      if (state == hps_pkg::ST_OFF && key_db) begin
         irq_n = 1'b0;
      end else if (state == hps_pkg::ST_HOLD_WAIT && next_state != state) begin
         irq_n = 1'b1;
      end else if (next_state == hps_pkg::ST_DOWN_RST || next_state == hps_pkg::ST_OFF) begin
         irq_n = 1'b1;
      end
   end

   // Outputs decoded from the next state so every pin is a flop
   always_ff @(posedge clk) begin
      if (reset) begin
         outs <= `HPS_OUT_RESET;
      end else begin
         outs.first_regulator_enable  <= (next_state != hps_pkg::ST_OFF);
         outs.second_regulator_enable <= (next_state == hps_pkg::ST_WAIT_SECOND) ||
                                         (next_state == hps_pkg::ST_RST_DLY) ||
                                         (next_state == hps_pkg::ST_HOLD_WAIT) ||
                                         (next_state == hps_pkg::ST_ON) ||
                                         (next_state == hps_pkg::ST_DOWN_RST && outs.second_regulator_enable);
         outs.host_reset_n            <= (next_state == hps_pkg::ST_HOLD_WAIT) ||
                                         (next_state == hps_pkg::ST_ON);
         outs.power_key_irq_n         <= irq_n;
      end
   end

   a_good_hyst: assert property (@(posedge clk) disable iff (reset)
      f.first_above_upper |=> good[0]) else $error("first good flag did not set");
   a_flag_latency: assert property (@(posedge clk) disable iff (reset)
      $fell(pins.second_above_lower) ##1 !pins.second_above_lower[*3] |-> ##[0:4] !good[1])
      else $error("second good flag slow to fall");
   a_deb_span: assert property (@(posedge clk) disable iff (reset)
      $changed(deb[1]) |-> $past(deb_cnt[1]) == DEBOUNCE_CYCLES - 1) else $error("key debounce too short");
   a_reset_release: assert property (@(posedge clk) disable iff (reset)
      $rose(outs.host_reset_n) |-> $past(state) == hps_pkg::ST_RST_DLY && $past(timer) == RESET_CYCLES - 1)
      else $error("host reset released at wrong time");
   a_second_off: assert property (@(posedge clk) disable iff (reset)
      $fell(outs.second_regulator_enable) |-> $past(state) == hps_pkg::ST_DOWN_RST &&
      $past(timer) == RESET_CYCLES - 1) else $error("second regulator off at wrong time");
   a_second_on: assert property (@(posedge clk) disable iff (reset)
      $rose(outs.second_regulator_enable) |-> $past(state) == hps_pkg::ST_REG_DLY &&
      $past(timer) == (opt_sel ? REG_OPT_CYCLES : REG_STD_CYCLES) - 1) else $error("second regulator early");
   a_first_off: assert property (@(posedge clk) disable iff (reset)
      $fell(outs.first_regulator_enable) |-> $past(state) == hps_pkg::ST_DOWN_REG && !good[1])
      else $error("first regulator off out of order");
   a_hold_timeout: assert property (@(posedge clk) disable iff (reset)
      state == hps_pkg::ST_HOLD_WAIT && timer == HOLD_CYCLES - 1 && !f.host_power_hold && charger_n_db
      && good == 2'h3 |=> !outs.host_reset_n && outs.power_key_irq_n) else $error("hold timeout ignored");
   a_hold_clears_irq: assert property (@(posedge clk) disable iff (reset)
      state == hps_pkg::ST_HOLD_WAIT && f.host_power_hold |=> outs.power_key_irq_n && outs.host_reset_n)
      else $error("interrupt not cleared by hold");
   a_key_start: assert property (@(posedge clk) disable iff (reset)
      state == hps_pkg::ST_OFF && key_db |=> outs.first_regulator_enable && !outs.power_key_irq_n)
      else $error("key press did not start up");
   a_fault_reset: assert property (@(posedge clk) disable iff (reset)
      state == hps_pkg::ST_ON && !good[0] |=> !outs.host_reset_n ##1 !outs.host_reset_n)
      else $error("fault did not assert host reset");
   a_charger_keeps: assert property (@(posedge clk) disable iff (reset)
      state == hps_pkg::ST_ON && !charger_n_db && good == 2'h3 |=> outs.host_reset_n)
      else $error("shutdown with charger present");

endmodule

/* testbench/hps_host_model.sv */
// Model of the host processor and the first two regulators around the sequencer.
// Assumes it sees the sequencer outputs and shares its clock; levels only.
`timescale 1ns/1ps
module hps_host_model #(
   parameter int RAMP     = 5,
   parameter int HOLD_DLY = 8
) (
   // Clock
   input  wire logic                     clk,
   // Sequencer outputs and scenario controls
   input  wire hps_pkg::hps_outputs_type outs,
   input  wire logic                     hold_enable,
   input  wire logic                     fault_first,
   // Host power hold and comparators: first upper, first lower, second upper, second lower
   output logic                          hold,
   output logic [3:0]                    cmp
);
   int lvl1 = 0;
   int lvl2 = 0;
   int hcnt = 0;

   // Outputs ramp one step a cycle; a fault collapses the first at once
   always @(posedge clk) begin
      if (fault_first) lvl1 <= 0;
      else if (outs.first_regulator_enable && lvl1 < RAMP) lvl1 <= lvl1 + 1;
      else if (!outs.first_regulator_enable && lvl1 > 0) lvl1 <= lvl1 - 1;
      if (outs.second_regulator_enable && lvl2 < RAMP) lvl2 <= lvl2 + 1;
      else if (!outs.second_regulator_enable && lvl2 > 0) lvl2 <= lvl2 - 1;
   end

   // Upper trip at full level, lower one step below: gives hysteresis
   assign cmp = {lvl1 == RAMP, lvl1 >= RAMP - 1, lvl2 == RAMP, lvl2 >= RAMP - 1};

   // Host raises hold a while after leaving reset, well inside the timeout
   always @(posedge clk) begin
      hcnt <= outs.host_reset_n ? hcnt + 1 : 0;
      hold <= hold_enable && outs.host_reset_n && hcnt >= HOLD_DLY;
   end
endmodule

/* testbench/tb_top.sv */
// Self-checking bench for the handset power sequencer with shortened delays.
// Assumes hps_sequencer and the host model; all timing measured in clk cycles.
`timescale 1ns/1ps
module tb_top;
   localparam int DEB = 20, RST = 30, STD = 10, OPT = 40, HLD = 60, RAMP = 5, HDLY = 8, W = 10;
   logic                     clk;
   logic                     reset;
   logic                     delay_option;
   logic                     key;
   logic                     chg_n;
   logic                     hold_enable;
   logic                     fault_first;
   logic                     hold;
   logic [3:0]               cmp;
   hps_pkg::hps_inputs_type  pins;
   hps_pkg::hps_outputs_type outs;
   int                       cyc = 0;
   int                       n_errors = 0;
   int                       checks = 0;
   int                       t;
   int                       t3;

   assign pins = {key, chg_n, hold, cmp};

   hps_sequencer #(.DEBOUNCE_CYCLES(DEB), .RESET_CYCLES(RST), .REG_STD_CYCLES(STD),
      .REG_OPT_CYCLES(OPT), .HOLD_CYCLES(HLD)) hps_sequencer_i (.clk(clk), .reset(reset),
      .delay_option(delay_option), .pins(pins), .outs(outs));
   hps_host_model #(.RAMP(RAMP), .HOLD_DLY(HDLY)) hps_host_model_i (.clk(clk), .outs(outs),
      .hold_enable(hold_enable), .fault_first(fault_first), .hold(hold), .cmp(cmp));

   // Clock and free-running cycle stamp
   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end
   always @(posedge clk) cyc <= cyc + 1;

   task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         n_errors++;
         $display("[ERR] %s expected %h seen %h", name, exp, seen);
      end
   endtask

   // Interval must start at lo; slack covers the three-stage sync and the filter flop
   task automatic in_rng(input string name, input int d, input int lo);
      check(name, {31'h0, d >= lo && d <= lo + W}, 32'h1);
   endtask

   task automatic tick(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask

   // Bounded wait on one output bit: 3 first, 2 second, 1 host reset, 0 irq
   task automatic wait_out(input string name, input int idx, input logic val, input int lim, output int ts);
      int n;
      n = 0;
      while (outs[idx] !== val && n < lim) begin
         tick(1);
         n++;
      end
      check(name, {31'h0, outs[idx] === val}, 32'h1);
      ts = cyc;
   endtask

   // Strap is sampled while reset is high
   task automatic do_reset(input logic opt);
      reset = 1'b1;
      delay_option = opt;
      key = 1'b0;
      chg_n = 1'b1;
      fault_first = 1'b0;
      tick(8);
      reset = 1'b0;
      tick(2);
      check("reset_outs", {28'h0, outs}, 32'h1);
   endtask

   task automatic power_up(input logic by_key, input logic opt, output int tr);
      int t0, t1, t2;
      t0 = cyc;
      if (by_key) key = 1'b1;
      else chg_n = 1'b0;
      wait_out("first_on", 3, 1'b1, DEB + 2 * W, t1);
      in_rng("debounce", t1 - t0, DEB);
      check("irq_at_start", {31'h0, outs.power_key_irq_n}, {31'h0, !by_key});
      key = 1'b0;
      wait_out("second_on", 2, 1'b1, 200, t2);
      in_rng("reg_delay", t2 - t1, (opt ? OPT : STD) + RAMP);
      wait_out("host_out_of_reset", 1, 1'b1, 200, tr);
      in_rng("reset_delay", tr - t2, RST + RAMP);
   endtask

   // Reverse order from the host reset fall at tf
   task automatic power_down(input int tf, input int reg_dly);
      int t2, t1;
      wait_out("second_off", 2, 1'b0, 200, t2);
      in_rng("down_reset_delay", t2 - tf, RST);
      wait_out("first_off", 3, 1'b0, 200, t1);
      in_rng("down_reg_delay", t1 - t2, reg_dly + 2);
   endtask

   task automatic s_glitch();
      do_reset(1'b0);
      key = 1'b1;
      tick(DEB / 2);
      key = 1'b0;
      chg_n = 1'b0;
      tick(DEB / 2);
      chg_n = 1'b1;
      tick(DEB + W);
      check("glitch_first_off", {31'h0, outs.first_regulator_enable}, 32'h0);
   endtask

   task automatic s_hold_ok();
      do_reset(1'b0);
      hold_enable = 1'b1;
      power_up(1'b1, 1'b0, t3);
      wait_out("irq_clear", 0, 1'b1, HDLY + W, t);
      tick(HLD + W);
      check("held_on", {31'h0, outs.host_reset_n}, 32'h1);
      hold_enable = 1'b0;
      wait_out("release_reset", 1, 1'b0, W, t);
      power_down(t, STD);
   endtask

   task automatic s_timeout();
      do_reset(1'b1);
      hold_enable = 1'b0;
      power_up(1'b1, 1'b1, t3);
      wait_out("timeout_reset", 1, 1'b0, HLD + 2 * W, t);
      in_rng("hold_timeout", t - t3, HLD);
      check("timeout_irq", {31'h0, outs.power_key_irq_n}, 32'h1);
      power_down(t, OPT);
   endtask

   task automatic s_fault();
      do_reset(1'b0);
      hold_enable = 1'b1;
      power_up(1'b1, 1'b0, t3);
      tick(HDLY + W);
      fault_first = 1'b1;
      wait_out("fault_reset", 1, 1'b0, 8, t);
      wait_out("fault_first_off", 3, 1'b0, RST + STD + 3 * W, t);
      fault_first = 1'b0;
   endtask

   task automatic s_charger();
      do_reset(1'b0);
      hold_enable = 1'b0;
      power_up(1'b0, 1'b0, t3);
      tick(HLD + W);
      check("charger_stays_on", {31'h0, outs.host_reset_n}, 32'h1);
      check("charger_no_irq", {31'h0, outs.power_key_irq_n}, 32'h1);
      chg_n = 1'b1;
      wait_out("unplug_reset", 1, 1'b0, DEB + W, t);
      power_down(t, STD);
   endtask

   task automatic report_and_stop();
      $display("checks=%0d n_errors=%0d", checks, n_errors);
      if (n_errors == 0 && checks > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask

   // Watchdog well above the few hundred cycles each scenario needs
   initial begin
      repeat (6000) @(posedge clk);
      n_errors++;
      report_and_stop();
   end

   initial begin
      reset = 1'b1;
      delay_option = 1'b0;
      key = 1'b0;
      chg_n = 1'b1;
      hold_enable = 1'b0;
      fault_first = 1'b0;
      s_glitch();
      s_hold_ok();
      s_timeout();
      s_fault();
      s_charger();
      report_and_stop();
   end
endmodule
